// ==== design/dcr_defs.svh ====
// Offsets, field positions, reset values and timing counts of the control registers
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH
`define DCR_OFF_ADDR 8'h00
`define DCR_OFF_RESET 8'h01
`define DCR_OFF_CFG 8'h02
`define DCR_ADDR_SRC_BIT 0
`define DCR_LOGIC_RST_BIT 0
`define DCR_FULL_RST_BIT 1
`define DCR_SLEEP_SEL_BIT 4
`define DCR_OSC_FB_BIT 5
`define DCR_OVR_BIT 6
`define DCR_OE_BIT 7
`define DCR_RESET_RST 8'h00
`define DCR_CFG_RST 8'h00
`define DCR_CFG_WMASK 8'hf0
`define DCR_RESET_WMASK 8'h03
`define DCR_PULSE_NS 100
`define DCR_CLK_NS 100
`define DCR_PULSE_CYC ((`DCR_PULSE_NS + `DCR_CLK_NS - 1) / `DCR_CLK_NS)
`endif

// ==== design/dcr_pkg.sv ====
// Types shared by the control register block
package dcr_pkg;
    typedef logic [7:0] dcr_byte_type;
    typedef logic [6:0] dcr_addr_type;
endpackage

// ==== design/dcr_regs.sv ====
// Address, soft reset and output behaviour control registers
`timescale 1ns/1ns
`include "dcr_defs.svh"

// How it works
// RULE_01 - Address register bits 7..1 hold the bus address, defaulting to strap.
// RULE_02 - Bit 0 clear uses strap address; set uses register address.
// RULE_03 - Reset bit 1 resets all logic and registers, then self-clears.
// RULE_04 - Full reset reloads strap-loaded registers from the original strap sample.
// RULE_05 - Reset bit 0 resets logic but keeps registers, then self-clears.
// RULE_06 - Config bit 7 gives output enable under override; otherwise forced to 1.
// RULE_07 - Software should pulse the logic reset after raising output enable.
// RULE_08 - Config bit 6 selects default behaviour or register override values.
// RULE_09 - Config bit 5 puts oscillator clock on pixel clock output when unlocked.
// RULE_10 - Config bit 4 gives the sleep-state override for the unlocked outputs.
// RULE_11 - Without override the sleep-state select is forced to 1.
// RULE_12 - Reserved bits read zero and ignore writes.
module dcr_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access from the two-wire bus decoder
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire dcr_pkg::dcr_byte_type regAddr,
    input wire dcr_pkg::dcr_byte_type regWrData,
    output dcr_pkg::dcr_byte_type regRdData,
    // Pins and link status
    input wire dcr_pkg::dcr_addr_type addrStrapPin,
    input wire logic linkLocked,
    // Controls to the rest of the device
    output dcr_pkg::dcr_addr_type ownBusAddr,
    output logic digitalReset,
    output logic registerReset,
    output logic outputEnable,
    output logic unlockedStateSel,
    output logic fallbackOscToPixclk
);
    import dcr_pkg::*;

    // ==========================================================
    // Strap capture
    dcr_addr_type strapSync;
    dcr_addr_type strap_reg;
    dcr_addr_type strap_next;
    logic strapValid_reg;
    logic strapValid_next;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_sync
            dcr_sync u_sync
            (
                .clk(clk),
                .rst(rst),
                .din(addrStrapPin[gi]),
                .dout(strapSync[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Register state
    dcr_byte_type addr_reg;
    dcr_byte_type addr_next;
    dcr_byte_type cfg_reg;
    dcr_byte_type cfg_next;
    dcr_byte_type rd_reg;
    dcr_byte_type rd_next;
    logic fullRst_reg;
    logic fullRst_next;
    logic logicRst_reg;
    logic logicRst_next;
    logic [1:0] warm_reg;
    logic [1:0] warm_next;

    // Strap sampled once, after the synchroniser has filled
    always_comb
    begin
        warm_next = (warm_reg == 2'd3) ? warm_reg : warm_reg + 2'd1;
        strapValid_next = strapValid_reg;
        strap_next = strap_reg;
        if (!strapValid_reg && warm_reg == 2'd3)
        begin
            strapValid_next = 1'b1;
            strap_next = strapSync;
        end
    end

    // Register writes; a full soft reset wins over any write
    always_comb
    begin
        addr_next = addr_reg;
        cfg_next = cfg_reg;
        fullRst_next = 1'b0;
        logicRst_next = 1'b0;
        if (!strapValid_reg && warm_reg == 2'd3)
            addr_next = {strapSync, 1'b0}; // see RULE_01
        if (fullRst_reg)
        begin
            addr_next = {strap_reg, 1'b0}; // see RULE_04
            cfg_next = `DCR_CFG_RST; // see RULE_03
        end
        else if (regWrEn)
        begin
            unique case (regAddr)
                `DCR_OFF_ADDR: addr_next = regWrData; // see RULE_01
                `DCR_OFF_RESET:
                begin
                    // Self-clearing: high only in the cycle after a write that sets the bit
                    fullRst_next = regWrData[`DCR_FULL_RST_BIT]; // see RULE_03
                    logicRst_next = regWrData[`DCR_LOGIC_RST_BIT]; // see RULE_05
                end
                `DCR_OFF_CFG: cfg_next = regWrData & `DCR_CFG_WMASK; // see RULE_12
                default: addr_next = addr_reg;
            endcase
        end
    end

    // Read data from a register; reset bits read back zero after self-clear
    always_comb
    begin
        rd_next = rd_reg;
        if (regRdEn)
        begin
            unique case (regAddr)
                `DCR_OFF_ADDR: rd_next = addr_reg;
                `DCR_OFF_RESET: rd_next = {6'h00, fullRst_reg, logicRst_reg} & `DCR_RESET_WMASK;
                `DCR_OFF_CFG: rd_next = cfg_reg & `DCR_CFG_WMASK; // see RULE_12
                default: rd_next = 8'h00;
            endcase
        end
    end

    // Registering of all state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            addr_reg <= 8'h00;
            cfg_reg <= `DCR_CFG_RST;
            rd_reg <= 8'h00;
            fullRst_reg <= 1'b0;
            logicRst_reg <= 1'b0;
            warm_reg <= 2'd0;
            strap_reg <= 7'h00;
            strapValid_reg <= 1'b0;
        end
        else
        begin
            addr_reg <= addr_next;
            cfg_reg <= cfg_next;
            rd_reg <= rd_next;
            fullRst_reg <= fullRst_next;
            logicRst_reg <= logicRst_next;
            warm_reg <= warm_next;
            strap_reg <= strap_next;
            strapValid_reg <= strapValid_next;
        end
    end

    // ==========================================================
    // Derived controls
    logic ovr;
    assign ovr = cfg_reg[`DCR_OVR_BIT]; // see RULE_08
    assign ownBusAddr = addr_reg[`DCR_ADDR_SRC_BIT] ? addr_reg[7:1] : strap_reg; // see RULE_02
    assign outputEnable = ovr ? cfg_reg[`DCR_OE_BIT] : 1'b1; // see RULE_06
    assign unlockedStateSel = ovr ? cfg_reg[`DCR_SLEEP_SEL_BIT] : 1'b1; // see RULE_10 RULE_11
    assign fallbackOscToPixclk = cfg_reg[`DCR_OSC_FB_BIT] & ~linkLocked; // see RULE_09
    // Both soft resets hit the logic; only the full one clears registers
    assign digitalReset = fullRst_reg | logicRst_reg; // see RULE_05
    assign registerReset = fullRst_reg; // see RULE_03
    assign regRdData = rd_reg;

    // ==========================================================
    // Checks
    property p_full_reload;
        @(posedge clk) disable iff (rst)
        fullRst_reg |=> (addr_reg == {$past(strap_reg), 1'b0}) && (cfg_reg == 8'h00);
    endproperty
    a_full_reload: assert property (p_full_reload) else $error("full reset reload wrong"); // see RULE_04

    property p_self_clear;
        @(posedge clk) disable iff (rst)
        (regWrEn && regAddr == `DCR_OFF_RESET && regWrData[`DCR_FULL_RST_BIT] && !fullRst_reg)
            |=> registerReset ##1 !registerReset;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("full reset not one pulse"); // see RULE_03

    property p_logic_keep;
        @(posedge clk) disable iff (rst)
        (logicRst_reg && !fullRst_reg) |-> digitalReset && !registerReset && $stable(cfg_reg);
    endproperty
    a_logic_keep: assert property (p_logic_keep) else $error("logic reset touched registers"); // see RULE_05

    property p_oe_default;
        @(posedge clk) disable iff (rst)
        !cfg_reg[6] |-> outputEnable && unlockedStateSel;
    endproperty
    a_oe_default: assert property (p_oe_default) else $error("defaults not forced"); // see RULE_06

    property p_ovr_vals;
        @(posedge clk) disable iff (rst)
        cfg_reg[6] |-> outputEnable == cfg_reg[7] && unlockedStateSel == cfg_reg[4];
    endproperty
    a_ovr_vals: assert property (p_ovr_vals) else $error("override values wrong"); // see RULE_08

    property p_osc;
        @(posedge clk) disable iff (rst)
        fallbackOscToPixclk == (cfg_reg[5] && !linkLocked);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator fallback wrong"); // see RULE_09

    property p_addr_sel;
        @(posedge clk) disable iff (rst)
        (regWrEn && regAddr == `DCR_OFF_ADDR && regWrData[`DCR_ADDR_SRC_BIT] && !fullRst_reg)
            |=> {ownBusAddr, 1'b1} == $past(regWrData);
    endproperty
    a_addr_sel: assert property (p_addr_sel) else $error("address source wrong"); // see RULE_02

    property p_addr_wr;
        @(posedge clk) disable iff (rst)
        (regWrEn && regAddr == 8'h00 && !fullRst_reg) |=> addr_reg == $past(regWrData);
    endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("address write lost"); // see RULE_01

    property p_rsvd;
        @(posedge clk) disable iff (rst)
        cfg_reg[3:0] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // see RULE_12

    c_full: cover property (@(posedge clk) disable iff (rst) registerReset);
    c_logic: cover property (@(posedge clk) disable iff (rst) digitalReset && !registerReset);
    c_ovr: cover property (@(posedge clk) disable iff (rst) cfg_reg[6] && !outputEnable);
    c_osc: cover property (@(posedge clk) disable iff (rst) fallbackOscToPixclk);
endmodule

// ==== design/dcr_sync.sv ====
// Two flip-flop synchroniser for one pin bit
`timescale 1ns/1ns
module dcr_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin side and synchronised side
    input wire logic din,
    output logic dout
);
    logic stage1_reg;
    logic stage1_next;
    logic stage2_reg;
    logic stage2_next;

    // First stage is read by the second stage only
    always_comb
    begin
        stage1_next = din;
        stage2_next = stage1_reg;
    end

    // Register both stages
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign dout = stage2_reg;
endmodule

// ==== tb/dcr_bus_model.sv ====
// Register bus controller model driving the decoder-side strobes
`timescale 1ns/1ns
module dcr_bus_model
(
    // Clock
    input wire logic clk,
    // Strobes and data toward the registers
    output logic regWrEn,
    output logic regRdEn,
    output dcr_pkg::dcr_byte_type regAddr,
    output dcr_pkg::dcr_byte_type regWrData,
    // Read answer
    input wire dcr_pkg::dcr_byte_type regRdData
);
    import dcr_pkg::*;
    // Idle from time zero
    initial
    begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // One write; released lines go inverted so stale values never look valid
    task automatic wr(input dcr_byte_type a, input dcr_byte_type d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    // One read; data taken mid-cycle once the registered answer settled
    task automatic rd(input dcr_byte_type a, output dcr_byte_type d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(negedge clk);
        d = regRdData;
    endtask
    // Raise output enable, then pulse the register-keeping reset
    task automatic oe_on(input dcr_byte_type cfg);
        wr(8'h02, cfg);
        wr(8'h01, 8'h01);
    endtask
endmodule

// ==== tb/test_dcr_regs.sv ====
// Self-checking bench for the address, soft reset and output registers
`timescale 1ns/1ns
module test_dcr_regs;
    import dcr_pkg::*;
    localparam dcr_addr_type strapVal = 7'h3c;
    logic clk, rst, regWrEn, regRdEn, linkLocked, digitalReset, registerReset;
    logic outputEnable, unlockedStateSel, fallbackOscToPixclk;
    dcr_byte_type regAddr, regWrData, regRdData, rdv;
    dcr_addr_type addrStrapPin, ownBusAddr;
    int bad_count = 0;
    int total_checks = 0;
    // ==========================================
    // Design and bus model
    dcr_regs u_dcr_regs (.clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .addrStrapPin(addrStrapPin), .linkLocked(linkLocked), .ownBusAddr(ownBusAddr),
        .digitalReset(digitalReset), .registerReset(registerReset),
        .outputEnable(outputEnable), .unlockedStateSel(unlockedStateSel),
        .fallbackOscToPixclk(fallbackOscToPixclk));
    dcr_bus_model u_dcr_bus_model (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
    // ==========================================
    // Helpers
    task automatic chk(input dcr_byte_type seen, input dcr_byte_type exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input dcr_byte_type a, input dcr_byte_type exp);
        u_dcr_bus_model.rd(a, rdv);
        chk(rdv, exp);
    endtask
    task automatic close_out();
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        rchk(8'h00, {strapVal, 1'b0});
        chk(ownBusAddr, strapVal);
        rchk(8'h01, 8'h00);
        rchk(8'h02, 8'h00);
        chk(outputEnable, 1'b1);
        chk(unlockedStateSel, 1'b1);
    endtask
    task automatic t_addr();
        u_dcr_bus_model.wr(8'h00, 8'h55);
        @(negedge clk);
        chk(ownBusAddr, 7'h2a);
        rchk(8'h00, 8'h55);
        u_dcr_bus_model.wr(8'h00, 8'h54);
        @(negedge clk);
        chk(ownBusAddr, strapVal);
        u_dcr_bus_model.wr(8'h05, 8'hff);
        rchk(8'h05, 8'h00);
    endtask
    task automatic t_cfg();
        u_dcr_bus_model.wr(8'h02, 8'hff);
        rchk(8'h02, 8'hf0);
        chk(outputEnable, 1'b1);
        chk(unlockedStateSel, 1'b1);
        @(posedge clk) linkLocked <= 1'b0;
        @(negedge clk) chk(fallbackOscToPixclk, 1'b1);
        @(posedge clk) linkLocked <= 1'b1;
        @(negedge clk) chk(fallbackOscToPixclk, 1'b0);
        u_dcr_bus_model.wr(8'h02, 8'h40);
        @(negedge clk);
        chk(outputEnable, 1'b0);
        chk(unlockedStateSel, 1'b0);
        @(posedge clk) linkLocked <= 1'b0;
        @(negedge clk) chk(fallbackOscToPixclk, 1'b0);
        @(posedge clk) linkLocked <= 1'b1;
        u_dcr_bus_model.wr(8'h02, 8'h20);
        @(negedge clk);
        chk(outputEnable, 1'b1);
        chk(unlockedStateSel, 1'b1);
    endtask
    task automatic t_logic();
        u_dcr_bus_model.oe_on(8'hc0);
        @(negedge clk);
        chk(digitalReset, 1'b1);
        chk(registerReset, 1'b0);
        @(negedge clk) chk(digitalReset, 1'b0);
        rchk(8'h02, 8'hc0);
    endtask
    // Strap moved first: the full reset must restore the first sample
    task automatic t_full();
        @(posedge clk) addrStrapPin <= 7'h15;
        u_dcr_bus_model.wr(8'h00, 8'h55);
        u_dcr_bus_model.wr(8'h01, 8'h02);
        @(negedge clk);
        chk(registerReset, 1'b1);
        chk(digitalReset, 1'b1);
        @(negedge clk);
        chk(registerReset, 1'b0);
        chk(ownBusAddr, strapVal);
        rchk(8'h00, {strapVal, 1'b0});
        rchk(8'h02, 8'h00);
        rchk(8'h01, 8'h00);
        // Both reset bits at once: the full reset must win for the registers
        u_dcr_bus_model.wr(8'h02, 8'h80);
        u_dcr_bus_model.wr(8'h01, 8'h03);
        @(negedge clk);
        chk(registerReset, 1'b1);
        @(negedge clk);
        chk(digitalReset, 1'b0);
        rchk(8'h02, 8'h00);
    endtask
    // ==========================================
    // Clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #(100 * 3000);
        bad_count++;
        close_out();
    end
    initial
    begin
        rst = 1'b1;
        addrStrapPin = strapVal;
        linkLocked = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Strap load finishes before the first request
        repeat (8) @(posedge clk);
        t_reset();
        t_addr();
        t_cfg();
        t_logic();
        t_full();
        close_out();
    end
endmodule
